/* File: hw/cdwd_regs.svh */
// register offsets, field positions, reset values and counts of the watchdog
// assumes apb byte addressing with one 32-bit word per register
`ifndef CDWD_REGS_SVH
`define CDWD_REGS_SVH
`define CDWD_OFF_START    12'h000
`define CDWD_OFF_EVENT    12'h100
`define CDWD_OFF_INTEN    12'h304
`define CDWD_OFF_INTCLR   12'h308
`define CDWD_OFF_RUN      12'h400
`define CDWD_OFF_REQSTAT  12'h404
`define CDWD_OFF_CRV      12'h504
`define CDWD_OFF_RELOAD_REQUEST_ENABLE     12'h508
`define CDWD_OFF_CONFIG   12'h50c
`define CDWD_OFF_RR0      12'h600
`define CDWD_OFF_IRQSTAT  12'h700
`define CDWD_OFF_IRQMASK  12'h704
`define CDWD_KEY          32'h6e524635
`define CDWD_CRV_RST      32'hffffffff
`define CDWD_RELOAD_REQUEST_ENABLE_RST     8'h01
`define CDWD_CFG_RST      2'h3
`define CDWD_CFG_SLEEP    0
`define CDWD_CFG_HALT     3
`define CDWD_RST_DELAY    2'h2
`endif

/* File: hw/cdwd_pkg.sv */
// types shared by the watchdog design
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package cdwd_pkg;
  // one-hot states of the watchdog
  typedef enum logic [3:0] {
    CDWD_IDLE  = 4'h1,  // not started
    CDWD_RUN   = 4'h2,  // counting
    CDWD_DELAY = 4'h4,  // expiry seen, reset postponed
    CDWD_FIRE  = 4'h8   // reset asserted
  } cdwd_state_t;
endpackage : cdwd_pkg
`default_nettype wire

/* File: hw/cdwd_top.sv */
// countdown watchdog with apb register slave and slow-clock tick input
// assumes slow_tick is a one-cycle pulse per 32.768 khz period, in pclk domain
`default_nettype none
`include "cdwd_regs.svh"
module cdwd_top (
  input  wire logic        pclk,          // bus clock, 40 mhz
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        clk_en,        // freezes all state when low
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        slow_tick,     // low_freq_clock tick pulse
  input  wire logic        cpu_sleep,     // processor sleeping
  input  wire logic        cpu_halted,    // debugger halt
  input  wire logic        other_lf_src,  // another slow source runs
  output logic             rc_osc_req,    // keep rc oscillator on
  output logic             wd_reset,      // reset request, level
  output logic             irq            // level interrupt
);
  // state and registers
  cdwd_pkg::cdwd_state_t state_r, state_nxt;
  logic [31:0] cnt_r;          // down-counter
  logic [31:0] crv_r;          // counter_reload_value
  logic [7:0]  reload_request_enable_r;         // reload_request_enable
  logic [1:0]  cfg_r;          // {halt keep, sleep keep} bits 3/0 mapped
  logic [7:0]  reqst_r;        // reload_request keys seen
  logic        event_r;        // expiry event flag
  logic        inten_r;        // expiry interrupt enable
  logic        ist_r;          // sticky interrupt status
  logic        imask_r;        // interrupt mask
  logic [1:0]  dly_r;          // ticks left before reset
  logic [31:0] prdata_r;

  // bus decode
  wire acc     = psel & penable & clk_en;
  wire wr      = acc & pwrite;
  wire rd      = acc & ~pwrite;
  wire started = (state_r != cdwd_pkg::CDWD_IDLE);
  wire cfg_wr  = wr & ~started;
  wire rr_hit  = ({paddr[11:5], 5'h00} == `CDWD_OFF_RR0);
  wire [2:0] rr_idx = paddr[4:2];
  wire key_ok  = wr & rr_hit & (pwdata == `CDWD_KEY);
  wire start_w = wr & (paddr == `CDWD_OFF_START) & pwdata[0];
  // one named hit per register keeps the decode readable
  wire hit_start  = (paddr == `CDWD_OFF_START);
  wire hit_event  = (paddr == `CDWD_OFF_EVENT);
  wire hit_inten  = (paddr == `CDWD_OFF_INTEN);
  wire hit_intclr = (paddr == `CDWD_OFF_INTCLR);
  wire hit_run    = (paddr == `CDWD_OFF_RUN);
  wire hit_reqst  = (paddr == `CDWD_OFF_REQSTAT);
  wire hit_crv    = (paddr == `CDWD_OFF_CRV);
  wire hit_reload_request_enable   = (paddr == `CDWD_OFF_RELOAD_REQUEST_ENABLE);
  wire hit_cfg    = (paddr == `CDWD_OFF_CONFIG);
  wire hit_ist    = (paddr == `CDWD_OFF_IRQSTAT);
  wire hit_imask  = (paddr == `CDWD_OFF_IRQMASK);
  wire known   = rr_hit | hit_start | hit_event | hit_inten | hit_intclr
               | hit_run | hit_reqst | hit_crv | hit_reload_request_enable | hit_cfg
               | hit_ist | hit_imask;

  // reload request bookkeeping
  wire [7:0] key_vec = key_ok ? (8'h01 << rr_idx) : 8'h00;
  wire [7:0] req_all = reqst_r | key_vec;
  wire reload = started & ((req_all & reload_request_enable_r) == reload_request_enable_r);

  // pause gating, default keeps counting
  wire paused = (cpu_sleep & ~cfg_r[0]) | (cpu_halted & ~cfg_r[1]);
  wire tick   = slow_tick & ~paused;
  wire expire = (state_r == cdwd_pkg::CDWD_RUN) & tick & (cnt_r == 32'h0);

  // next-state logic
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cdwd_pkg::CDWD_IDLE: begin
        if (start_w) begin
          state_nxt = cdwd_pkg::CDWD_RUN;
        end
      end
      cdwd_pkg::CDWD_RUN: begin
        if (expire) begin
          state_nxt = inten_r ? cdwd_pkg::CDWD_DELAY : cdwd_pkg::CDWD_FIRE;
        end
      end
      cdwd_pkg::CDWD_DELAY: begin
        // raw tick: the delay is wall time, pause does not stretch it
        if (slow_tick & (dly_r == 2'h1)) begin
          state_nxt = cdwd_pkg::CDWD_FIRE;
        end
      end
      cdwd_pkg::CDWD_FIRE: begin
        state_nxt = cdwd_pkg::CDWD_FIRE; // only presetn leaves
      end
      default: begin
        state_nxt = cdwd_pkg::CDWD_IDLE;
      end
    endcase
  end

  // state register
  // fire is only left through presetn, so nothing cancels a due reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= cdwd_pkg::CDWD_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // counter
  // start and reload share one load path from the reload value
  // a wrap from zero is the expiry itself, the count is not reused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 32'h0;
    end else if (clk_en) begin
      if (start_w & ~started) begin
        cnt_r <= crv_r;
      end else if (state_r == cdwd_pkg::CDWD_RUN & reload) begin
        cnt_r <= crv_r;
      end else if (state_r == cdwd_pkg::CDWD_RUN & tick) begin
        cnt_r <= cnt_r - 32'h1;
      end
    end
  end

  // reload-request progress, cleared once a reload happens
  // keys written before start are kept and count after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reqst_r <= 8'h00;
    end else if (clk_en) begin
      reqst_r <= reload ? 8'h00 : req_all;
    end
  end

  // configuration registers, locked after start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crv_r  <= `CDWD_CRV_RST;
      reload_request_enable_r <= `CDWD_RELOAD_REQUEST_ENABLE_RST;
      cfg_r  <= `CDWD_CFG_RST;
    end else if (cfg_wr) begin
      if (paddr == `CDWD_OFF_CRV) begin
        crv_r <= pwdata;
      end
      if (paddr == `CDWD_OFF_RELOAD_REQUEST_ENABLE) begin
        reload_request_enable_r <= pwdata[7:0];
      end
      if (paddr == `CDWD_OFF_CONFIG) begin
        cfg_r <= {pwdata[`CDWD_CFG_HALT], pwdata[`CDWD_CFG_SLEEP]};
      end
    end
  end

  // postponement counter
  // counts raw ticks: pausing must not stretch a pending reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_r <= 2'h0;
    end else if (clk_en) begin
      if (expire) begin
        dly_r <= `CDWD_RST_DELAY;
      end else if (state_r == cdwd_pkg::CDWD_DELAY & slow_tick) begin
        dly_r <= dly_r - 2'h1;
      end
    end
  end

  // event, interrupt enable, sticky status and mask; set wins
  wire ev_clr  = wr & (paddr == `CDWD_OFF_EVENT) & ~pwdata[0];
  wire ist_rd  = rd & (paddr == `CDWD_OFF_IRQSTAT);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_r <= 1'b0;
      inten_r <= 1'b0;
      ist_r   <= 1'b0;
      imask_r <= 1'b0;
    end else if (clk_en) begin
      event_r <= expire | (event_r & ~ev_clr);
      ist_r   <= expire | (ist_r & ~ist_rd);
      if (wr & (paddr == `CDWD_OFF_INTEN) & pwdata[0]) begin
        inten_r <= 1'b1;
      end else if (wr & (paddr == `CDWD_OFF_INTCLR) & pwdata[0]) begin
        inten_r <= 1'b0;
      end
      if (wr & (paddr == `CDWD_OFF_IRQMASK)) begin
        imask_r <= pwdata[0];
      end
    end
  end

  // read mux
  // unmapped reads return zero alongside pslverr
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0;
    case (paddr)
      `CDWD_OFF_EVENT:   rmux = {31'h0, event_r};
      `CDWD_OFF_INTEN:   rmux = {31'h0, inten_r};
      `CDWD_OFF_INTCLR:  rmux = {31'h0, inten_r};
      `CDWD_OFF_RUN:     rmux = {31'h0, started};
      `CDWD_OFF_REQSTAT: rmux = {24'h0, reqst_r};
      `CDWD_OFF_CRV:     rmux = crv_r;
      `CDWD_OFF_RELOAD_REQUEST_ENABLE:    rmux = {24'h0, reload_request_enable_r};
      `CDWD_OFF_CONFIG:  rmux = {28'h0, cfg_r[1], 2'h0, cfg_r[0]};
      `CDWD_OFF_IRQSTAT: rmux = {31'h0, ist_r};
      `CDWD_OFF_IRQMASK: rmux = {31'h0, imask_r};
      default:           rmux = 32'h0;
    endcase
  end

  // read data register, updated at the edge that ends the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (psel & ~penable & clk_en) begin
      prdata_r <= rmux; // captured in setup so it is valid in access
    end
  end

  // outputs
  assign prdata     = prdata_r;
  assign pready     = clk_en;           // zero wait states while clk_en is high, wait states while it is low
  assign pslverr    = psel & penable & ~known;
  assign irq        = ist_r & imask_r;
  assign wd_reset   = (state_r == cdwd_pkg::CDWD_FIRE);
  assign rc_osc_req = started & ~other_lf_src;

  // assertions: all on pclk, quiet while presetn is low

  // helper: unpaused ticks seen since the counter was last loaded
  wire ld_now = (start_w & ~started)
              | ((state_r == cdwd_pkg::CDWD_RUN) & reload);
  logic [31:0] per_cnt_r;  // ticks since start or reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_r <= 32'h0;
    end else if (clk_en) begin
      if (ld_now) begin
        per_cnt_r <= 32'h0;  // fresh period
      end else if ((state_r == cdwd_pkg::CDWD_RUN) & tick) begin
        per_cnt_r <= per_cnt_r + 32'h1;
      end
    end
  end

  // helper: raw ticks seen while the reset is postponed
  logic [1:0] post_r;  // counts up from the expiry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_r <= 2'h0;
    end else if (clk_en) begin
      if (expire) begin
        post_r <= 2'h0;  // new postponement starts
      end else if ((state_r == cdwd_pkg::CDWD_DELAY) & slow_tick) begin
        post_r <= post_r + 2'h1;
      end
    end
  end

  // expiry without interrupt resets at the next edge
  exp_fire_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en & expire & ~inten_r |=> wd_reset)
    else $error("no reset after expiry");
  // expiry with interrupt holds the reset back
  delay_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en & expire & inten_r |=> ~wd_reset)
    else $error("reset not postponed");
  // postponed reset comes after exactly two raw ticks
  delay_len_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en & $rose(wd_reset) & inten_r |-> post_r == 2'h2)
    else $error("postponement length wrong");
  // a raised reset stays until presetn
  fire_stick_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wd_reset |=> wd_reset)
    else $error("pending reset cancelled");
  // nothing moves the counter before start
  idle_cnt_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ~started & ~start_w |=> $stable(cnt_r))
    else $error("counter moved before start");
  // start loads the reload value
  start_load_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en & start_w & ~started |=> cnt_r == $past(crv_r))
    else $error("start did not load");
  // reload value is frozen while started
  lock_crv_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    started & $past(started) |-> $stable(crv_r))
    else $error("config changed after start");
  // request enables are frozen while started
  lock_reload_request_enable_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    started & $past(started) |-> $stable(reload_request_enable_r))
    else $error("enables changed after start");
  // pause configuration is frozen while started
  lock_cfg_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    started & $past(started) |-> $stable(cfg_r))
    else $error("pause config changed after start");
  // before start a reload value write lands
  unlock_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en & wr & ~started & (paddr == `CDWD_OFF_CRV)
    |=> crv_r == $past(pwdata))
    else $error("config locked while idle");
  // oscillator request rises only on start or loss of the other source
  osc_req_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(rc_osc_req) |-> $past(start_w) | $fell(other_lf_src))
    else $error("oscillator request wrong");
  // a wrong value leaves the key record alone
  bad_key_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en & wr & rr_hit & (pwdata != `CDWD_KEY) & ~reload
    |=> reqst_r == $past(reqst_r))
    else $error("non-key write counted");
  // full key set reloads the counter
  reload_load_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en & (state_r == cdwd_pkg::CDWD_RUN) & reload
    |=> cnt_r == $past(crv_r))
    else $error("reload did not load");
  // an incomplete key set does not touch the counter
  reload_need_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en & (state_r == cdwd_pkg::CDWD_RUN) & ~reload & ~tick
    |=> $stable(cnt_r))
    else $error("counter reloaded early");
  // each unpaused tick takes one off
  tick_dec_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en & (state_r == cdwd_pkg::CDWD_RUN) & tick & ~reload
    & (cnt_r != 32'h0) |=> cnt_r == $past(cnt_r) - 32'h1)
    else $error("counter did not decrement");
  // expiry sets the event and the sticky status
  event_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en & expire |=> event_r & ist_r)
    else $error("expiry not flagged");
  // expiry falls on the tick after reload value ticks
  period_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en & expire |-> per_cnt_r == crv_r)
    else $error("period length wrong");
  // with both keep bits set, sleep and halt do not stop counting
  keep_run_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en & (state_r == cdwd_pkg::CDWD_RUN) & slow_tick
    & (cfg_r == 2'h3) & ~reload & (cnt_r != 32'h0)
    |=> cnt_r == $past(cnt_r) - 32'h1)
    else $error("stopped while keep set");
  // a pause holds the count
  pause_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en & (state_r == cdwd_pkg::CDWD_RUN) & paused & ~reload
    |=> $stable(cnt_r))
    else $error("counted while paused");

  // main scenarios seen at least once
  c_start_c: cover property (@(posedge pclk) disable iff (!presetn)
    start_w & ~started);
  c_reload_c: cover property (@(posedge pclk) disable iff (!presetn)
    reload & (state_r == cdwd_pkg::CDWD_RUN));
  c_delay_c: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == cdwd_pkg::CDWD_DELAY ##[1:300] wd_reset);
  c_pause_c: cover property (@(posedge pclk) disable iff (!presetn)
    (state_r == cdwd_pkg::CDWD_RUN) & paused & slow_tick);
endmodule : cdwd_top
`default_nettype wire

/* File: tb/cdwd_far_model.sv */
// far side of the watchdog: slow tick source, cpu sleep/halt, clock status
// assumes the bench's pclk; tick period is scaled down from the real ratio
`default_nettype none
module cdwd_far_model #(
  parameter int PERIOD = 64  // pclk cycles per slow tick
) (
  input  wire logic pclk,
  input  wire logic sleep_in,
  input  wire logic halt_in,
  input  wire logic other_in,
  output logic      slow_tick,
  output logic      cpu_sleep,
  output logic      cpu_halted,
  output logic      other_lf_src
);
  timeunit 1ns;
  timeprecision 1ps;
  int div = 0;  // free-running divider, the slow clock never stops
  // outputs settle at the first pclk edge, well inside reset
  // one pclk-wide tick per period; status passes through one register
  always @(posedge pclk) begin
    div <= (div == PERIOD - 1) ? 0 : div + 1;
    slow_tick <= (div == PERIOD - 1);
    cpu_sleep <= sleep_in;
    cpu_halted <= halt_in;
    other_lf_src <= other_in;
  end
endmodule : cdwd_far_model
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the countdown watchdog over apb
// assumes design, register header and far-side model are compiled first
`default_nettype none
`include "cdwd_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h00010d32;
  logic        pready, pslverr, err, slow_tick, cpu_sleep, cpu_halted;
  logic        other_lf_src, rc_osc_req, wd_reset, irq;
  logic        sleep_in = 1'b0, halt_in = 1'b0, other_in = 1'b0;
  logic        clk_en = 1'b1;
  logic [7:0]  reload_request_enable, cfg;
  int          failures = 0, n_compared = 0, ticks = 0, pticks = 0, counter_reload_value;
  bit          started = 1'b0;
  always #12.5 pclk = ~pclk;
  cdwd_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_tick(slow_tick), .cpu_sleep(cpu_sleep), .cpu_halted(cpu_halted),
    .other_lf_src(other_lf_src), .rc_osc_req(rc_osc_req),
    .wd_reset(wd_reset), .irq(irq));
  cdwd_far_model far_u (.pclk(pclk), .sleep_in(sleep_in), .halt_in(halt_in),
    .other_in(other_in), .slow_tick(slow_tick), .cpu_sleep(cpu_sleep),
    .cpu_halted(cpu_halted), .other_lf_src(other_lf_src));
  // reference count: raw ticks since start and ticks that pause ignores
  always @(posedge pclk) begin
    if (slow_tick && started) begin
      ticks <= ticks + 1;
      if ((cpu_sleep && !cfg[0]) || (cpu_halted && !cfg[3])) begin
        pticks <= pticks + 1;
      end
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer, entered just after an edge; waits on pready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdc
  // bounded wait for a level; a hang counts as a mismatch
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (s !== 1'b1 && n < 3000);
    if (n >= 3000) failures++;
  endtask : wait_hi
  // configure and start right after a tick so counts stay aligned
  task automatic setup_start(input logic [7:0] c);
    counter_reload_value = 4 + rnd() % 5;
    reload_request_enable = 8'(rnd()) | 8'h80;  // last request always takes part
    cfg = c;
    apb(1'b1, `CDWD_OFF_CRV, counter_reload_value);
    apb(1'b1, `CDWD_OFF_RELOAD_REQUEST_ENABLE, {24'h0, reload_request_enable});
    apb(1'b1, `CDWD_OFF_CONFIG, {24'h0, c});
    wait_hi(slow_tick);
    apb(1'b1, `CDWD_OFF_START, 32'h1);
    started = 1'b1;
    ticks = 0;
    pticks = 0;
    rdc(`CDWD_OFF_RUN, 32'h1);
  endtask : setup_start
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`CDWD_OFF_CONFIG, 32'h9);
    rdc(`CDWD_OFF_RUN, 32'h0);
    repeat (2) wait_hi(slow_tick);
    check(wd_reset, 1'b0);
    check(rc_osc_req, 1'b0);
    apb(1'b0, 12'h7f0, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    clk_en <= 1'b0;
    @(posedge pclk);
    check(pready, 1'b0);
    clk_en <= 1'b1;
    @(posedge pclk);
    setup_start(8'h09);
    check(rc_osc_req, 1'b1);
    other_in <= 1'b1;
    repeat (3) @(posedge pclk);
    check(rc_osc_req, 1'b0);
    other_in <= 1'b0;
    apb(1'b1, `CDWD_OFF_CRV, 32'h100);
    rdc(`CDWD_OFF_CRV, counter_reload_value);
    sleep_in <= 1'b1;
    halt_in <= 1'b1;
    wait_hi(slow_tick);
    sleep_in <= 1'b0;
    halt_in <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      if (reload_request_enable[i]) apb(1'b1, `CDWD_OFF_RR0 + 4 * i, `CDWD_KEY);
    end
    apb(1'b1, `CDWD_OFF_RR0 + 28, ~`CDWD_KEY);
    rdc(`CDWD_OFF_REQSTAT, {24'h0, reload_request_enable & 8'h7f});
    wait_hi(slow_tick);
    apb(1'b1, `CDWD_OFF_RR0 + 28, `CDWD_KEY);
    ticks = 0;
    rdc(`CDWD_OFF_REQSTAT, 32'h0);
    wait_hi(wd_reset);
    check(ticks, counter_reload_value + 1);
    check(irq, 1'b0);
    $display("test reload and lock done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    started = 1'b0;
    @(posedge pclk);
    check(wd_reset, 1'b0);
    rdc(`CDWD_OFF_CRV, `CDWD_CRV_RST);
    setup_start(8'h00);
    apb(1'b1, `CDWD_OFF_INTEN, 32'h1);
    apb(1'b1, `CDWD_OFF_IRQMASK, 32'h1);
    sleep_in <= 1'b1;
    repeat (2) wait_hi(slow_tick);
    sleep_in <= 1'b0;
    halt_in <= 1'b1;
    repeat (2) wait_hi(slow_tick);
    halt_in <= 1'b0;
    wait_hi(irq);
    check(ticks - pticks, counter_reload_value + 1);
    check(wd_reset, 1'b0);
    rdc(`CDWD_OFF_EVENT, 32'h1);
    apb(1'b1, `CDWD_OFF_EVENT, 32'h0);
    rdc(`CDWD_OFF_IRQSTAT, 32'h1);
    check(irq, 1'b0);
    wait_hi(wd_reset);
    check(ticks - pticks, counter_reload_value + 3);
    $display("test pause and delayed reset done");
    final_report();
  end
endmodule : tb
`default_nettype wire
